// file: pkg/sts_defs.svh
// constants of the supply and thermal supervisor
// What this block does
// - the buck clock is the oscillator clock halved, and further divided clocks feed core, timers, pwm and converter.
// - software trims the oscillator by plus or minus ten percent through the trim register.
// - while the die is above the warning level the temperature event is raised, which interrupts the host only when unmasked.
// - a temperature warning during power-down wakes the device.
// - above the critical level the critical flag is logged and the device shuts down to reset at once.
// - the thermal fault stays active while the die remains above the warning level.
// - the critical flag survives the shutdown so software can read it after power-up.
// - above the highest level the digital core gets a power-on reset at once.
// - an undervoltage setting loaded from one-time memory picks 2.5 V to 3.25 V in 50 mV steps.
// - a hysteresis setting loaded from one-time memory puts supply-good 100 mV to 450 mV above undervoltage.
// - a supply below supply-good raises the supply warning event, which interrupts only when unmasked.
// - a supply below undervoltage for more than 100 ms in run mode logs the supply fault and starts shutdown to reset.
// - the active-low reset output is asserted when that shutdown starts.
// - the supply fault is also shown on an active-low supply fault output.
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define STS_ADDR_PAGE    8'h00
`define STS_ADDR_STATUS  8'h01
`define STS_ADDR_FAULT   8'h05
`define STS_ADDR_EVENTA  8'h06
`define STS_ADDR_EVENTB  8'h07
`define STS_ADDR_MASKA   8'h0A
`define STS_ADDR_MASKB   8'h0B
`define STS_ADDR_TRIM    8'h40
`define STS_ADDR_SUPCFG  8'h41
`define STS_ADDR_CTRL    8'h42

// ----------------------------------------
// field positions
// ----------------------------------------
`define STS_FLT_TEMP     4
`define STS_FLT_VDD      2
`define STS_EVB_VDDWARN  7
`define STS_EVB_TEMP     1
`define STS_STA_WAKE     1
`define STS_CTL_PWRDN    0

// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define STS_MASK_RESET   8'h00
`define STS_REG_RESET    8'h00
`define STS_UVSEL_RESET  4'h0
`define STS_HYST_RESET   3'h0
`define STS_SYNC_ONES    3'h7
`define STS_TRIM_RESET   5'h10
`define STS_TRIM_MAX     5'h14
`define STS_UV_MAX       4'hF
`define STS_HYST_MAX     3'h7

// ----------------------------------------
// timing
// ----------------------------------------
`define STS_CLK_HZ       50000000
`define STS_UV_TIME_MS   100
`define STS_UV_CYCLES    ((`STS_CLK_HZ / 1000) * `STS_UV_TIME_MS + 1)
`define STS_SYNC_ZERO    3'h0

`endif

// file: pkg/sts_pkg.sv
// types of the supply and thermal supervisor
package sts_pkg;
  typedef enum logic [1:0] {
    STS_RUN,
    STS_SHUTDOWN,
    STS_RESET
  } sts_mode_type;
endpackage : sts_pkg

// file: core/sts_supervisor.sv
// supply and thermal supervisor with clock dividers and register port
`timescale 1ns/1ns
`include "sts_defs.svh"

module sts_supervisor #(
  parameter int UV_CYCLES = `STS_UV_CYCLES,
  parameter int DIV_WIDTH = 8
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       tempWarnIn,
  input  wire logic       tempCritIn,
  input  wire logic       tempPorIn,
  input  wire logic       supplyGoodIn,
  input  wire logic       supplyUvIn,
  input  wire logic       otpLoad,
  input  wire logic [3:0] otpUvSelect,
  input  wire logic [2:0] otpHystSelect,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  output logic            irq,
  output logic            wakeUp,
  output logic            corePorReq,
  output logic            system_reset_out_n,
  output logic            supply_fault_out_n,
  output logic      [4:0] oscillator_trim,
  output logic      [3:0] undervoltage_threshold_select,
  output logic      [2:0] supply_hysteresis_select,
  output logic            buckClk,
  output logic [DIV_WIDTH-1:0] divClk
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [2:0] syncWarn, syncCrit, syncPor, syncGood, syncUv;
  logic       tempWarn, tempCrit, tempPor, supplyGood, supplyUv;

  function automatic logic filt(input logic [2:0] s, input logic prev);
    // change accepted once the second and third stages agree
    filt = (s[1] == s[2]) ? s[2] : prev;
  endfunction : filt

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncWarn <= `STS_SYNC_ZERO;
      syncCrit <= `STS_SYNC_ZERO;
      syncPor  <= `STS_SYNC_ZERO;
      syncGood <= `STS_SYNC_ONES;
      syncUv   <= `STS_SYNC_ZERO;
      tempWarn <= 1'b0;
      tempCrit <= 1'b0;
      tempPor  <= 1'b0;
      supplyGood <= 1'b1;
      supplyUv <= 1'b0;
    end else begin
      syncWarn <= {syncWarn[1:0], tempWarnIn};
      syncCrit <= {syncCrit[1:0], tempCritIn};
      syncPor  <= {syncPor[1:0], tempPorIn};
      syncGood <= {syncGood[1:0], supplyGoodIn};
      syncUv   <= {syncUv[1:0], supplyUvIn};
      tempWarn <= filt(syncWarn, tempWarn);
      tempCrit <= filt(syncCrit, tempCrit);
      tempPor  <= filt(syncPor, tempPor);
      supplyGood <= filt(syncGood, supplyGood);
      supplyUv <= filt(syncUv, supplyUv);
    end
  end

  // ----------------------------------------
  // clock division
  // ----------------------------------------
  logic [DIV_WIDTH-1:0] divCount;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divCount <= '0;
    end else begin
      divCount <= divCount + 1'b1;
    end
  end

  // bit 0 toggles at half the clock rate; higher bits give the slower taps
  assign buckClk = divCount[0];
  assign divClk  = divCount;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  logic [7:0] pageSel, faultLog, eventA, eventB, maskA, maskB, statusA;
  logic       powerDown;
  sts_pkg::sts_mode_type mode, next_mode;

  wire wrPage   = regWrite && (regAddr == `STS_ADDR_PAGE);
  wire wrFault  = regWrite && (regAddr == `STS_ADDR_FAULT);
  wire wrEventA = regWrite && (regAddr == `STS_ADDR_EVENTA);
  wire wrEventB = regWrite && (regAddr == `STS_ADDR_EVENTB);
  wire wrMaskA  = regWrite && (regAddr == `STS_ADDR_MASKA);
  wire wrMaskB  = regWrite && (regAddr == `STS_ADDR_MASKB);
  wire wrTrim   = regWrite && (regAddr == `STS_ADDR_TRIM);
  wire wrSupCfg = regWrite && (regAddr == `STS_ADDR_SUPCFG);
  wire wrCtrl   = regWrite && (regAddr == `STS_ADDR_CTRL);

  // ----------------------------------------
  // undervoltage qualification
  // ----------------------------------------
  logic [31:0] uvCount;
  wire         uvExpired = supplyUv && (uvCount >= 32'(UV_CYCLES));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      uvCount <= '0;
    end else if (!supplyUv) begin
      uvCount <= '0;
    end else if (!uvExpired) begin
      uvCount <= uvCount + 32'd1;
    end
  end

  // ----------------------------------------
  // events
  // ----------------------------------------
  wire tempEvent = tempWarn;
  wire vddEvent  = !supplyGood;
  wire critEvent = tempCrit;
  wire uvEvent   = uvExpired && (mode == sts_pkg::STS_RUN);

  wire [7:0] setEventB = ({7'h00, tempEvent} << `STS_EVB_TEMP) | ({7'h00, vddEvent} << `STS_EVB_VDDWARN);
  wire [7:0] setFault  = ({7'h00, critEvent} << `STS_FLT_TEMP) | ({7'h00, uvEvent} << `STS_FLT_VDD);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eventA   <= `STS_REG_RESET;
      eventB   <= `STS_REG_RESET;
      maskA    <= `STS_MASK_RESET;
      maskB    <= `STS_MASK_RESET;
      pageSel  <= `STS_REG_RESET;
    end else begin
      // set wins over a write-one clear in the same cycle
      eventA <= wrEventA ? (eventA & ~regWdata) : eventA;
      eventB <= (wrEventB ? (eventB & ~regWdata) : eventB) | setEventB;
      if (wrMaskA) maskA <= regWdata;
      if (wrMaskB) maskB <= regWdata;
      if (wrPage) pageSel <= regWdata;
    end
  end

  // the fault log is cleared only by software, never by the shutdown
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      faultLog <= `STS_REG_RESET;
    end else begin
      faultLog <= (wrFault ? (faultLog & ~regWdata) : faultLog) | setFault;
    end
  end

  // ----------------------------------------
  // trim and supply settings
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oscillator_trim <= `STS_TRIM_RESET;
      undervoltage_threshold_select <= `STS_UVSEL_RESET;
      supply_hysteresis_select <= `STS_HYST_RESET;
      powerDown <= 1'b0;
    end else begin
      // codes beyond the range are clamped to the ten percent limit
      if (wrTrim) oscillator_trim <= (regWdata[4:0] > `STS_TRIM_MAX) ? `STS_TRIM_MAX : regWdata[4:0];
      if (otpLoad) begin
        undervoltage_threshold_select <= otpUvSelect;
        supply_hysteresis_select      <= otpHystSelect;
      end else if (wrSupCfg) begin
        undervoltage_threshold_select <= regWdata[3:0];
        supply_hysteresis_select      <= regWdata[6:4];
      end
      // the wake wins over a software write in the same cycle, so a hot die is never missed
      if (tempEvent && powerDown) powerDown <= 1'b0;
      else if (wrCtrl) powerDown <= regWdata[`STS_CTL_PWRDN];
    end
  end

  // ----------------------------------------
  // mode control
  // ----------------------------------------
  always_comb begin
    next_mode = mode;
    case (mode)
      sts_pkg::STS_RUN: begin
        if (critEvent) next_mode = sts_pkg::STS_RESET;
        else if (uvEvent) next_mode = sts_pkg::STS_SHUTDOWN;
      end
      sts_pkg::STS_SHUTDOWN: begin
        next_mode = sts_pkg::STS_RESET;
      end
      sts_pkg::STS_RESET: begin
        // held while the die stays hot or the supply is low
        // the critical level is checked too, so a lone critical input cannot toggle the mode
        if (!tempWarn && !tempCrit && !supplyUv) next_mode = sts_pkg::STS_RUN;
      end
      default: begin
        next_mode = sts_pkg::STS_RESET;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= sts_pkg::STS_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq                <= 1'b0;
      wakeUp             <= 1'b0;
      corePorReq         <= 1'b0;
      system_reset_out_n <= 1'b1;
      supply_fault_out_n <= 1'b1;
    end else begin
      irq <= |(eventA & ~maskA) || |(eventB & ~maskB);
      wakeUp <= tempEvent && powerDown;
      corePorReq <= tempPor;
      system_reset_out_n <= !(next_mode != sts_pkg::STS_RUN);
      supply_fault_out_n <= !faultLog[`STS_FLT_VDD];
    end
  end

  // mode in bits 3:2, power-down request in bit 1
  assign statusA = {4'h0, 2'(mode), powerDown, 1'b0};

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [7:0] readMux;

  always_comb begin
    if (regAddr == `STS_ADDR_PAGE) readMux = pageSel;
    else if (regAddr == `STS_ADDR_STATUS) readMux = statusA;
    else if (regAddr == `STS_ADDR_FAULT) readMux = faultLog;
    else if (regAddr == `STS_ADDR_EVENTA) readMux = eventA;
    else if (regAddr == `STS_ADDR_EVENTB) readMux = eventB;
    else if (regAddr == `STS_ADDR_MASKA) readMux = maskA;
    else if (regAddr == `STS_ADDR_MASKB) readMux = maskB;
    else if (regAddr == `STS_ADDR_TRIM) readMux = {3'h0, oscillator_trim};
    else if (regAddr == `STS_ADDR_SUPCFG) readMux = {1'b0, supply_hysteresis_select, undervoltage_threshold_select};
    else if (regAddr == `STS_ADDR_CTRL) readMux = {7'h00, powerDown};
    else readMux = 8'h00;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata <= `STS_REG_RESET;
    end else begin
      regRdata <= regRead ? readMux : 8'h00;
    end
  end

endmodule : sts_supervisor

// file: tb/sts_host_model.sv
// host processor model driving the register port of the supervisor
`timescale 1ns/1ns
module sts_host_model (
  input  wire logic       clk,
  output logic      [7:0] regAddr,
  output logic      [7:0] regWdata,
  output logic            regWrite,
  output logic            regRead
);
  initial begin
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
  end

  // one-cycle write strobe, released only after the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
  endtask : rd
endmodule : sts_host_model

// file: tb/sts_supervisor_chk.sv
// port assertions of the supply and thermal supervisor
`timescale 1ns/1ns
`include "sts_defs.svh"
module sts_supervisor_chk #(
  parameter int UV_CYCLES = `STS_UV_CYCLES
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       tempWarnIn,
  input wire logic       tempCritIn,
  input wire logic       tempPorIn,
  input wire logic       supplyUvIn,
  input wire logic       regRead,
  input wire logic       regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic       wakeUp,
  input wire logic       corePorReq,
  input wire logic       system_reset_out_n,
  input wire logic       supply_fault_out_n,
  input wire logic [4:0] oscillator_trim,
  input wire logic       buckClk
);
  // saturating run length of the raw undervoltage level
  int uvRun;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      uvRun <= 0;
    end else if (!supplyUvIn) begin
      uvRun <= 0;
    end else if (uvRun < UV_CYCLES + 100) begin
      uvRun <= uvRun + 1;
    end
  end

  // a software clear of the supply fault bit may release the pin
  wire faultClr = regWrite && (regAddr == `STS_ADDR_FAULT) && regWdata[`STS_FLT_VDD];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence sWarnGone; !tempWarnIn [*8]; endsequence
  sequence sPorHeld; tempPorIn [*8]; endsequence
  sequence sCritHeld; tempCritIn [*8]; endsequence

  a_buck_half: assert property (
    $past(arst_n) |-> buckClk != $past(buckClk)) else $error("buck clock missed a toggle");
  a_trim_max: assert property (
    oscillator_trim <= `STS_TRIM_MAX) else $error("trim above its upper limit");
  a_rdata_idle: assert property (
    !$past(regRead) |-> regRdata == 8'h00) else $error("read data outside its cycle");
  a_wake_cause: assert property (
    sWarnGone |=> !wakeUp) else $error("wake-up without temperature warning");
  a_por_follow: assert property (
    sPorHeld |=> corePorReq) else $error("core reset request missing");
  a_por_release: assert property (
    !tempPorIn [*8] |=> !corePorReq) else $error("core reset request without cause");
  a_crit_reset: assert property (
    sCritHeld |=> !system_reset_out_n) else $error("no reset on critical temperature");
  a_crit_hold: assert property (
    tempWarnIn [*6] ##0 !system_reset_out_n |=> !system_reset_out_n) else $error("reset left while hot");
  a_uv_qualify: assert property (
    $fell(supply_fault_out_n) |-> uvRun >= UV_CYCLES) else $error("supply fault before qualification");
  a_uv_deadline: assert property (
    uvRun == UV_CYCLES + 8 |-> !system_reset_out_n && !supply_fault_out_n) else $error("supply fault late");
  a_fault_sticky: assert property (
    !supply_fault_out_n && !$past(faultClr) |=> !supply_fault_out_n) else $error("supply fault pin released");
endmodule : sts_supervisor_chk

bind sts_supervisor sts_supervisor_chk #(.UV_CYCLES(UV_CYCLES)) i_chk (
  .clk(clk), .arst_n(arst_n), .tempWarnIn(tempWarnIn), .tempCritIn(tempCritIn), .tempPorIn(tempPorIn),
  .supplyUvIn(supplyUvIn), .regRead(regRead), .regRdata(regRdata), .wakeUp(wakeUp),
  .corePorReq(corePorReq), .system_reset_out_n(system_reset_out_n), .supply_fault_out_n(supply_fault_out_n),
  .oscillator_trim(oscillator_trim), .buckClk(buckClk), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite));

// file: tb/testbench.sv
// self-checking bench of the supply and thermal supervisor
`timescale 1ns/1ns
module testbench;
  localparam int UV = 20;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       rdPend = 1'b0;
  logic       tempWarnIn, tempCritIn, tempPorIn, supplyGoodIn, supplyUvIn, otpLoad, b;
  logic       regWrite, regRead, irq, wakeUp, corePorReq, system_reset_out_n, supply_fault_out_n, buckClk;
  logic [3:0] otpUvSelect, undervoltage_threshold_select;
  logic [2:0] otpHystSelect, supply_hysteresis_select;
  logic [4:0] oscillator_trim;
  logic [7:0] regAddr, regWdata, regRdata, t, divClk;
  logic [7:0] qExp[$];
  int         n_errors = 0;
  int         n_checks = 0;
  wire logic [4:0] obs = {irq, wakeUp, corePorReq, system_reset_out_n, supply_fault_out_n};

  always #10 clk = ~clk;
  sts_host_model i_host (.clk(clk), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead));
  sts_supervisor #(.UV_CYCLES(UV)) i_dut (.clk(clk), .arst_n(arst_n), .tempWarnIn(tempWarnIn),
    .tempCritIn(tempCritIn), .tempPorIn(tempPorIn), .supplyGoodIn(supplyGoodIn), .supplyUvIn(supplyUvIn),
    .otpLoad(otpLoad), .otpUvSelect(otpUvSelect), .otpHystSelect(otpHystSelect), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq),
    .wakeUp(wakeUp), .corePorReq(corePorReq), .system_reset_out_n(system_reset_out_n),
    .supply_fault_out_n(supply_fault_out_n), .oscillator_trim(oscillator_trim),
    .undervoltage_threshold_select(undervoltage_threshold_select),
    .supply_hysteresis_select(supply_hysteresis_select), .buckClk(buckClk), .divClk(divClk));

  // ------------------------------------
  // checking helpers
  // ------------------------------------
  task automatic test_done;
    if (n_errors == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic rdExp(input logic [7:0] a, input logic [7:0] e);
    qExp.push_back(e);
    i_host.rd(a);
  endtask : rdExp

  // bounded wait for one observed pin to reach a level
  task automatic waitBit(input int i, input logic v);
    int k;
    k = 0;
    while (obs[i] !== v && k < 400) begin
      @(negedge clk);
      k++;
    end
    check("output pin", {7'h00, v}, {7'h00, obs[i]});
    if (obs[i] !== v) begin
      test_done();
    end
  endtask : waitBit

  always @(posedge clk) rdPend <= regRead;
  always @(negedge clk) begin
    if (rdPend === 1'b1) begin
      check("regRdata", qExp.pop_front(), regRdata);
    end
  end

  // ------------------------------------
  // scenarios
  // ------------------------------------
  initial begin
    tempWarnIn = 1'b0;
    tempCritIn = 1'b0;
    tempPorIn = 1'b0;
    supplyGoodIn = 1'b1;
    supplyUvIn = 1'b0;
    otpLoad = 1'b0;
    otpUvSelect = 4'h0;
    otpHystSelect = 3'h0;
    t = 8'($urandom(32'hA7A4));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    check("trim", 8'h10, {3'h0, oscillator_trim});
    rdExp(8'h0B, 8'h00);
    i_host.wr(8'h01, 8'hFF);
    rdExp(8'h01, 8'h00);
    i_host.wr(8'h20, 8'hFF);
    rdExp(8'h20, 8'h00);
    @(negedge clk);
    b = buckClk;
    t = divClk;
    @(negedge clk);
    check("buckClk", {7'h00, ~b}, {7'h00, buckClk});
    check("divClk", t + 8'h01, divClk);
    for (int i = 0; i < 4; i++) begin
      t = (i == 3) ? 8'h1F : 8'($urandom % 21);
      i_host.wr(8'h40, t);
      t = (t > 8'h14) ? 8'h14 : t;
      rdExp(8'h40, t);
      check("trim", t, {3'h0, oscillator_trim});
    end
    @(posedge clk);
    otpUvSelect <= 4'($urandom);
    otpHystSelect <= 3'($urandom);
    otpLoad <= 1'b1;
    @(posedge clk);
    otpLoad <= 1'b0;
    @(negedge clk);
    check("uvSelect", {4'h0, otpUvSelect}, {4'h0, undervoltage_threshold_select});
    check("hystSelect", {5'h00, otpHystSelect}, {5'h00, supply_hysteresis_select});
    i_host.wr(8'h42, 8'h01);
    @(posedge clk);
    tempWarnIn <= 1'b1;
    waitBit(3, 1'b1);
    waitBit(4, 1'b1);
    rdExp(8'h07, 8'h02);
    rdExp(8'h42, 8'h00);
    // the host masks the temperature interrupt
    i_host.wr(8'h0B, 8'h02);
    waitBit(4, 1'b0);
    @(posedge clk);
    supplyGoodIn <= 1'b0;
    waitBit(4, 1'b1);
    rdExp(8'h07, 8'h82);
    i_host.wr(8'h0B, 8'h82);
    rdExp(8'h0B, 8'h82);
    waitBit(4, 1'b0);
    @(posedge clk);
    supplyGoodIn <= 1'b1;
    tempWarnIn <= 1'b0;
    repeat (10) @(posedge clk);
    i_host.wr(8'h07, 8'hFF);
    rdExp(8'h07, 8'h00);
    // two short dips, each one shorter than the qualification time
    repeat (2) begin
      @(posedge clk);
      supplyUvIn <= 1'b1;
      repeat (UV - 2) @(posedge clk);
      supplyUvIn <= 1'b0;
      repeat (8) @(posedge clk);
    end
    check("faultPin", 8'h01, {7'h00, supply_fault_out_n});
    supplyUvIn <= 1'b1;
    waitBit(1, 1'b0);
    waitBit(0, 1'b0);
    rdExp(8'h05, 8'h04);
    @(posedge clk);
    supplyUvIn <= 1'b0;
    waitBit(1, 1'b1);
    @(posedge clk);
    tempWarnIn <= 1'b1;
    tempCritIn <= 1'b1;
    waitBit(1, 1'b0);
    @(posedge clk);
    tempCritIn <= 1'b0;
    repeat (20) @(posedge clk);
    check("resetPin", 8'h00, {7'h00, system_reset_out_n});
    rdExp(8'h01, 8'h08);
    @(posedge clk);
    tempWarnIn <= 1'b0;
    waitBit(1, 1'b1);
    rdExp(8'h05, 8'h14);
    // software clears the supply fault bit; the pin must follow
    i_host.wr(8'h05, 8'h04);
    rdExp(8'h05, 8'h10);
    waitBit(0, 1'b1);
    @(posedge clk);
    tempPorIn <= 1'b1;
    waitBit(2, 1'b1);
    @(posedge clk);
    tempPorIn <= 1'b0;
    waitBit(2, 1'b0);
    repeat (2) @(negedge clk);
    test_done();
  end
endmodule : testbench
